// file: core/core_tick_countdown_timer.sv
// Core tick countdown timer with AXI4-Lite register slave
`timescale 1ns/1ps
module core_tick_countdown_timer #(
   parameter int CNT_W = tick_timer_pkg::CNT_W
) (
   input  wire logic                               clock,
   input  wire logic                               rstn,
   input  wire logic                               ce,
   input  wire logic                               fast_pll_clock,
   input  wire logic                               s_axi_awvalid,
   output logic                                    s_axi_awready,
   input  wire logic [tick_timer_pkg::ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                               s_axi_wvalid,
   output logic                                    s_axi_wready,
   input  wire logic [tick_timer_pkg::DATA_W-1:0]  s_axi_wdata,
   input  wire logic [tick_timer_pkg::STRB_W-1:0]  s_axi_wstrb,
   output logic                                    s_axi_bvalid,
   input  wire logic                               s_axi_bready,
   output logic [1:0]                              s_axi_bresp,
   input  wire logic                               s_axi_arvalid,
   output logic                                    s_axi_arready,
   input  wire logic [tick_timer_pkg::ADDR_W-1:0]  s_axi_araddr,
   output logic                                    s_axi_rvalid,
   input  wire logic                               s_axi_rready,
   output logic [tick_timer_pkg::DATA_W-1:0]       s_axi_rdata,
   output logic [1:0]                              s_axi_rresp,
   output logic                                    tick_exception_line,
   output logic                                    deep_sleep_wake
);
   localparam int DW = tick_timer_pkg::DATA_W;
   localparam int AW = tick_timer_pkg::ADDR_W;
   localparam int SW = tick_timer_pkg::STRB_W;

   tick_timer_pkg::ctrl_t  ctrl_r;
   logic [CNT_W-1:0]       reload_r;
   logic [CNT_W-1:0]       count_r;
   logic                   pend_r;
   logic                   flag_r;
   logic                   tick_s;
   logic                   aw_got_r;
   logic                   w_got_r;
   logic [AW-1:0]          waddr_r;
   logic [DW-1:0]          wdata_r;
   logic [SW-1:0]          wstrb_r;
   logic                   wr_do;
   logic                   wr_ctrl;
   logic                   wr_reload;
   logic                   wr_current;
   logic                   rd_do;
   logic                   rd_ctrl;
   logic [DW-1:0]          rd_nxt;
   logic [DW-1:0]          ctrl_word;
   logic [DW-1:0]          ctrl_nxt;
   logic [DW-1:0]          reload_nxt;
   logic                   count_step;
   logic                   count_load;

   function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_v,
                                           input logic [DW-1:0] new_v,
                                           input logic [SW-1:0] strb);
      logic [DW-1:0] res;
      res = old_v;
      for (int i = 0; i < SW; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // ****************************************************************
   // Tick source
   // ****************************************************************
   tick_source #(
      .DIV (tick_timer_pkg::FAST_DIV)
   ) u_tick (
      .clock          (clock),
      .rstn           (rstn),
      .ce             (ce),
      .fast_pll_clock (fast_pll_clock),
      .clk_sel        (ctrl_r.clk_sel),
      .tick           (tick_s)
   );

   // ****************************************************************
   // AXI4-Lite write channel
   // ****************************************************************
   assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_got_r & ~s_axi_bvalid;
   assign wr_do         = ce & aw_got_r & w_got_r & ~s_axi_bvalid;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         aw_got_r <= 1'b0;
         waddr_r  <= '0;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            waddr_r  <= s_axi_awaddr;
         end else if (wr_do) begin
            aw_got_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         w_got_r <= 1'b0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end else if (ce) begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end else if (wr_do) begin
            w_got_r <= 1'b0;
         end
      end
   end

   assign wr_ctrl    = wr_do & (waddr_r == tick_timer_pkg::OFS_CONTROL);
   assign wr_reload  = wr_do & (waddr_r == tick_timer_pkg::OFS_RELOAD);
   assign wr_current = wr_do & (waddr_r == tick_timer_pkg::OFS_CURRENT);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= tick_timer_pkg::RESP_OKAY;
      end else if (ce) begin
         if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_ctrl | wr_reload | wr_current) ?
                            tick_timer_pkg::RESP_OKAY :
                            tick_timer_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Control and reload registers
   // ****************************************************************
   assign ctrl_word = {{(DW-1-tick_timer_pkg::BIT_FLAG){1'b0}}, flag_r,
                       {(tick_timer_pkg::BIT_FLAG-3){1'b0}},
                       ctrl_r.clk_sel, ctrl_r.irq_en, ctrl_r.enable};
   assign ctrl_nxt   = merge(ctrl_word, wdata_r, wstrb_r);
   assign reload_nxt = merge(DW'(reload_r), wdata_r, wstrb_r);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ctrl_r <= tick_timer_pkg::CTRL_RST;
      end else if (ce && wr_ctrl) begin
         ctrl_r.enable  <= ctrl_nxt[tick_timer_pkg::BIT_ENABLE];
         ctrl_r.irq_en  <= ctrl_nxt[tick_timer_pkg::BIT_IRQ_EN];
         ctrl_r.clk_sel <= ctrl_nxt[tick_timer_pkg::BIT_CLK_SEL];
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         reload_r <= tick_timer_pkg::RELOAD_RST;
      end else if (ce && wr_reload) begin
         reload_r <= reload_nxt[CNT_W-1:0];
      end
   end

   // ****************************************************************
   // Counter
   // ****************************************************************
   assign count_step = tick_s & ctrl_r.enable;
   assign count_load = pend_r | (count_r == '0);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         count_r <= tick_timer_pkg::CURRENT_RST;
      end else if (count_step) begin
         if (count_load) begin
            count_r <= reload_r;
         end else begin
            count_r <= count_r - 1'b1;
         end
      end
   end

   // A write and a tick in one cycle keep the request for the next tick
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pend_r <= 1'b0;
      end else if (ce) begin
         if (wr_current) begin
            pend_r <= 1'b1;
         end else if (count_step) begin
            pend_r <= 1'b0;
         end
      end
   end

   // Zero flag: set wins over read-clear and over a current-value write
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         flag_r <= 1'b0;
      end else if (ce) begin
         if (count_step && !pend_r && count_r == CNT_W'(1)) begin
            flag_r <= 1'b1;
         end else if (rd_ctrl || wr_current) begin
            flag_r <= 1'b0;
         end
      end
   end

   assign tick_exception_line = flag_r & ctrl_r.irq_en;
   // Sources are not gated in deep sleep, so no wake request exists
   assign deep_sleep_wake = 1'b0;

   // ****************************************************************
   // AXI4-Lite read channel
   // ****************************************************************
   assign s_axi_arready = ~s_axi_rvalid;
   assign rd_do   = ce & s_axi_arvalid & s_axi_arready;
   assign rd_ctrl = rd_do & (s_axi_araddr == tick_timer_pkg::OFS_CONTROL);

   always_comb begin
      rd_nxt = '0;
      unique case (s_axi_araddr)
         tick_timer_pkg::OFS_CONTROL: rd_nxt = ctrl_word;
         tick_timer_pkg::OFS_RELOAD:  rd_nxt = DW'(reload_r);
         tick_timer_pkg::OFS_CURRENT: rd_nxt = DW'(count_r);
         default:                     rd_nxt = '0;
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= tick_timer_pkg::RESP_OKAY;
      end else if (ce) begin
         if (rd_do) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_nxt;
            s_axi_rresp  <= (s_axi_araddr == tick_timer_pkg::OFS_CONTROL ||
                             s_axi_araddr == tick_timer_pkg::OFS_RELOAD  ||
                             s_axi_araddr == tick_timer_pkg::OFS_CURRENT) ?
                            tick_timer_pkg::RESP_OKAY :
                            tick_timer_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   count_down_a: assert property (@(posedge clock) disable iff (!rstn)
      count_step && !count_load |=> count_r == $past(count_r) - 1'b1)
      else $error("counter did not step down by one");

   fast_spacing_a: assert property (@(posedge clock) disable iff (!rstn)
      tick_s && ctrl_r.clk_sel == tick_timer_pkg::SEL_FAST_DIV3
      |=> !tick_s [*2])
      else $error("divided fast tick came too often");

   bus_every_a: assert property (@(posedge clock) disable iff (!rstn)
      ce && ctrl_r.clk_sel == tick_timer_pkg::SEL_BUS_CLOCK |-> tick_s)
      else $error("bus clock source missed a tick");

   sel_default_a: assert property (@(posedge clock) disable iff (!rstn)
      !$past(rstn) |-> ctrl_r.clk_sel == tick_timer_pkg::SEL_FAST_DIV3)
      else $error("clock select not fast divided after reset");

   zero_flag_a: assert property (@(posedge clock) disable iff (!rstn)
      count_step && !pend_r && count_r == CNT_W'(1) ##0 ctrl_r.irq_en
      |=> flag_r && count_r == '0 ##0 tick_exception_line)
      else $error("zero count did not raise the request");

   write_reload_a: assert property (@(posedge clock) disable iff (!rstn)
      pend_r && count_step |=> count_r == $past(reload_r))
      else $error("current value write did not reload");

   hold_off_a: assert property (@(posedge clock) disable iff (!rstn)
      !ctrl_r.enable |=> $stable(count_r))
      else $error("counter moved while disabled");

   reload_reg_a: assert property (@(posedge clock) disable iff (!rstn)
      wr_reload && wstrb_r == '1 |=> reload_r == $past(wdata_r[CNT_W-1:0]))
      else $error("reload register not written");

   wrap_a: assert property (@(posedge clock) disable iff (!rstn)
      count_step && count_r == '0 |=> count_r == $past(reload_r))
      else $error("counter did not reload after zero");

   bresp_hold_a: assert property (@(posedge clock) disable iff (!rstn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped before taken");

   wrap_c: cover property (@(posedge clock) disable iff (!rstn)
      count_step && count_r == '0);
   irq_c: cover property (@(posedge clock) disable iff (!rstn)
      $rose(tick_exception_line));
   restart_c: cover property (@(posedge clock) disable iff (!rstn)
      wr_current ##[1:20] count_step);

endmodule

// file: core/tick_timer_pkg.sv
// Constants, register map and field types for the core tick timer
package tick_timer_pkg;

   // ****************************************************************
   // Geometry
   // ****************************************************************
   localparam int          CNT_W       = 24;
   localparam int          DATA_W      = 32;
   localparam int          ADDR_W      = 4;
   localparam int          STRB_W      = DATA_W / 8;
   localparam int          FAST_DIV    = 3;
   localparam int          DIV_W       = 2;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_RELOAD  = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_CURRENT = 4'h8;

   // Control/status field positions
   localparam int          BIT_ENABLE  = 0;
   localparam int          BIT_IRQ_EN  = 1;
   localparam int          BIT_CLK_SEL = 2;
   localparam int          BIT_FLAG    = 16;

   // Clock select encodings
   localparam logic        SEL_FAST_DIV3 = 1'b0;
   localparam logic        SEL_BUS_CLOCK = 1'b1;

   // Reset values
   localparam logic [CNT_W-1:0] RELOAD_RST  = 24'h000000;
   localparam logic [CNT_W-1:0] CURRENT_RST = 24'h000000;

   // AXI responses
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic clk_sel;
      logic irq_en;
      logic enable;
   } ctrl_t;

   localparam ctrl_t CTRL_RST = '{clk_sel: SEL_FAST_DIV3,
                                  irq_en:  1'b0,
                                  enable:  1'b0};

endpackage

// file: core/tick_source.sv
// Tick source: fast clock divided by three or every bus clock cycle
`timescale 1ns/1ps
module tick_source #(
   parameter int DIV = tick_timer_pkg::FAST_DIV
) (
   input  wire logic clock,
   input  wire logic rstn,
   input  wire logic ce,
   input  wire logic fast_pll_clock,
   input  wire logic clk_sel,
   output logic      tick
);
   logic                               sync1_r;
   logic                               sync2_r;
   logic                               sync3_r;
   logic [tick_timer_pkg::DIV_W-1:0]   div_r;
   logic                               edge_s;

   // ****************************************************************
   // Synchroniser and edge detect
   // ****************************************************************
   // Fast clock must run below half the bus clock to be seen
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         sync3_r <= 1'b0;
      end else if (ce) begin
         sync1_r <= fast_pll_clock;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   assign edge_s = sync2_r & ~sync3_r;

   // ****************************************************************
   // Divide by three
   // ****************************************************************
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         div_r <= '0;
      end else if (ce && edge_s) begin
         if (div_r == tick_timer_pkg::DIV_W'(DIV - 1)) begin
            div_r <= '0;
         end else begin
            div_r <= div_r + 1'b1;
         end
      end
   end

   // Source choice
   assign tick = ce & ((clk_sel == tick_timer_pkg::SEL_BUS_CLOCK) |
                 (edge_s & (div_r == tick_timer_pkg::DIV_W'(DIV - 1))));

endmodule

// file: sim/core_tick_countdown_timer_test.sv
// Self-checking bench for the core tick countdown timer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
   fail_count++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module core_tick_countdown_timer_test;
   // ****************************************************************
   // Signals and constants
   // ****************************************************************
   logic        clock, rstn, ce, fast, irq, wake;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [3:0]  awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp, resp;
   int          fail_count, compares, cycles;
   localparam logic [3:0]  A_CTL = tick_timer_pkg::OFS_CONTROL;
   localparam logic [3:0]  A_RLD = tick_timer_pkg::OFS_RELOAD;
   localparam logic [3:0]  A_CUR = tick_timer_pkg::OFS_CURRENT;
   localparam logic [31:0] EN  = 32'h1 << tick_timer_pkg::BIT_ENABLE;
   localparam logic [31:0] IE  = 32'h1 << tick_timer_pkg::BIT_IRQ_EN;
   localparam logic [31:0] BUS = 32'h1 << tick_timer_pkg::BIT_CLK_SEL;
   localparam logic [31:0] FLG = 32'h1 << tick_timer_pkg::BIT_FLAG;
   localparam logic [1:0]  OK  = tick_timer_pkg::RESP_OKAY;
   localparam logic [1:0]  ERR = tick_timer_pkg::RESP_SLVERR;
   typedef struct {
      logic [3:0]  addr;
      logic [31:0] wd;
      logic [3:0]  strb;
      logic [31:0] rd;
      logic [1:0]  br;
      logic [1:0]  rr;
   } row_t;
   // Strobe row relies on the all-ones row before it
   row_t rows[5] = '{
      '{A_RLD, 32'hffffffff, 4'hf, 32'h00ffffff, OK, OK},
      '{A_RLD, 32'h00000055, 4'h1, 32'h00ffff55, OK, OK},
      '{A_RLD, 32'h12abcdef, 4'hf, 32'h00abcdef, OK, OK},
      '{A_CTL, 32'hfffffff8, 4'hf, 32'h00000000, OK, OK},
      '{4'hc,  32'h00000001, 4'hf, 32'h00000000, ERR, ERR}};

   core_tick_countdown_timer core_tick_countdown_timer_inst (
      .clock(clock), .rstn(rstn), .ce(ce), .fast_pll_clock(fast),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .tick_exception_line(irq), .deep_sleep_wake(wake));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // ****************************************************************
   // Bus and stimulus tasks
   // ****************************************************************
   task automatic wr(input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge clock);
         if (!aw_done && awready) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do @(posedge clock); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask

   // Reads a register and compares data and response
   task automatic rd(input logic [3:0] a, input logic [31:0] e,
                     input logic [1:0] er, input string nm);
      logic [31:0] d;
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clock); while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge clock); while (rvalid !== 1'b1);
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
      `CHK(nm, e, d)
      `CHK({nm, " resp"}, er, resp)
   endtask

   // Slow pin pulses; every third rise is one tick
   task automatic pulses(input int n);
      repeat (n) begin
         fast <= 1'b1;
         repeat (4) @(posedge clock);
         fast <= 1'b0;
         repeat (4) @(posedge clock);
      end
   endtask

   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         summarize();
      end
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      fail_count = 0;
      compares = 0;
      cycles = 0;
      rstn = 1'b0;
      ce = 1'b1;
      fast = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = '0;
      repeat (16) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      `CHK("irq reset", 1'b0, irq)
      `CHK("wake", 1'b0, wake)
      rd(A_CTL, 32'h0, OK, "ctl reset");
      rd(A_CUR, 32'h0, OK, "cur reset");
      $display("test reset done");
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wd, rows[i].strb);
         `CHK("row bresp", rows[i].br, resp)
         rd(rows[i].addr, rows[i].rd, rows[i].rr, "row data");
      end
      $display("test register rows done");
      // Fast clock divided by three
      wr(A_RLD, 32'h4, 4'hf);
      wr(A_CUR, 32'h0, 4'hf);
      wr(A_CTL, IE, 4'hf);
      wr(A_CTL, EN | IE, 4'hf);
      pulses(3);
      rd(A_CUR, 32'h4, OK, "first load");
      pulses(3);
      rd(A_CUR, 32'h3, OK, "count down");
      pulses(2);
      rd(A_CUR, 32'h3, OK, "two rises");
      pulses(1);
      rd(A_CUR, 32'h2, OK, "third rise");
      pulses(6);
      `CHK("irq at zero", 1'b1, irq)
      rd(A_CUR, 32'h0, OK, "zero");
      rd(A_CTL, EN | IE | FLG, OK, "flag set");
      `CHK("irq cleared", 1'b0, irq)
      rd(A_CTL, EN | IE, OK, "flag clear");
      pulses(3);
      rd(A_CUR, 32'h4, OK, "auto reload");
      pulses(3);
      wr(A_CUR, 32'h0, 4'hf);
      pulses(3);
      rd(A_CUR, 32'h4, OK, "restart");
      wr(A_CTL, IE, 4'hf);
      pulses(6);
      rd(A_CUR, 32'h4, OK, "disabled");
      $display("test fast clock done");
      // Bus clock: every cycle is a tick, reload of zero parks it
      wr(A_RLD, 32'h0, 4'hf);
      wr(A_CTL, EN | BUS, 4'hf);
      repeat (10) @(posedge clock);
      rd(A_CUR, 32'h0, OK, "bus count");
      `CHK("irq masked", 1'b0, irq)
      rd(A_CTL, EN | BUS | FLG, OK, "bus flag");
      repeat (10) @(posedge clock);
      rd(A_CTL, EN | BUS, OK, "zero reload");
      `CHK("wake bus", 1'b0, wake)
      $display("test bus clock done");
      // Reset in mid-run while enabled and parked at zero
      rstn <= 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      rd(A_CTL, 32'h0, OK, "ctl rerun");
      rd(A_RLD, 32'h0, OK, "rld rerun");
      $display("test second reset done");
      summarize();
   end
endmodule
